// ### rtl/dcst_top.sv
// Decimal counter group: complement subtraction, end-around carry and total readout with reset
// Notes on behaviour
// - Never counts backwards; subtract adds complement
// - Nines complement spans whole counter group
// - End-around carry adds one into units
// - Subtract: start at 9, turning from 21
// - Sensed hole stops wheel twelve points later
// - One unit per 18 points moved
// - Stop declutches and locks until next start
// - Top digit zero true, nine complement
// - True magnitude is nine minus each digit
// - Total reads out and zeroes in one cycle
// - Total: start at 351, turning from 3
// - Nine-to-zero arms stop and print impulse
// - Digit impulses every 18 points, 9 to 171
// - Four stored: detect 98, impulse 99, zero
`timescale 1ns/1ps
`include "dcst_defs.svh"
module dcst_top (
  input  wire logic                         i_sys_clk,
  input  wire logic                         i_reset,
  input  wire logic                         i_ce,
  input  wire dcst_pkg::dcst_op_req_type    i_op_req,
  input  wire logic                         i_end_around,
  input  wire logic [`DCST_POSITIONS-1:0]   i_hole,
  output logic [`DCST_PHASE_W-1:0]          o_phase,
  output dcst_pkg::dcst_op_type             o_op,
  output dcst_pkg::dcst_group_type          o_digits,
  output dcst_pkg::dcst_group_type          o_true_digits,
  output logic                              o_complement,
  output logic                              o_sign_fault,
  output dcst_pkg::dcst_print_type          o_print
);
  import dcst_pkg::*;

  localparam int N = `DCST_POSITIONS;

  logic [`DCST_PHASE_W-1:0] phase;
  dcst_op_type              op;
  dcst_impulse_type         impulse;
  logic [N-1:0]             hole_s1;
  logic [N-1:0]             hole_s2;
  logic [N-1:0]             hole_s3;
  logic [N-1:0]             hole;
  logic [N-1:0]             start;
  logic [N-1:0]             stop;
  logic [N-1:0]             carry_in;
  logic [N-1:0]             clutched;
  logic [N-1:0]             nine_ten;
  logic [N-1:0]             carry;
  logic [N-1:0]             printed;
  logic [N-1:0]             print_now;
  logic [`DCST_DIGIT_W-1:0] digit [N];
  dcst_group_type           group;
  logic                     is_sub;
  logic                     is_total;

  // Cycle-point impulse decoding
  function automatic dcst_impulse_type decode_impulse(input logic [`DCST_PHASE_W-1:0] ph);
    dcst_impulse_type r;
    r = '0;
    for (int k = 0; k < `DCST_IMP_COUNT; k++) begin
      if (ph == `DCST_PHASE_W'(`DCST_IMP_FIRST + `DCST_IMP_STEP * k)) begin
        r.valid = 1'b1;
        r.digit = `DCST_DIGIT_NINE - `DCST_DIGIT_W'(k);
      end
    end
    if (ph == `DCST_SPECIAL_IMP) begin
      r.valid   = 1'b1;
      r.special = 1'b1;
    end
    return r;
  endfunction

  function automatic logic [`DCST_DIGIT_W-1:0] nines(input logic [`DCST_DIGIT_W-1:0] d);
    return `DCST_DIGIT_NINE - d;
  endfunction

  assign impulse  = decode_impulse(phase);
  assign is_sub   = (op == DCST_OP_SUBTRACT);
  assign is_total = (op == DCST_OP_TOTAL);

  // Degree counter, one point per enabled clock
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      phase <= `DCST_PHASE_ZERO;
    end else if (i_ce) begin
      phase <= (phase == `DCST_PHASE_LAST) ? `DCST_PHASE_ZERO : phase + `DCST_PHASE_ONE;
    end
  end

  // Operation for the window from the total start point onward
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      op <= DCST_OP_IDLE;
    end else if (i_ce && (phase == `DCST_OP_LATCH)) begin
      if (i_op_req.total) begin
        op <= DCST_OP_TOTAL;
      end else if (i_op_req.subtract) begin
        op <= DCST_OP_SUBTRACT;
      end else begin
        op <= DCST_OP_IDLE;
      end
    end
  end

  // Brush contacts come from outside; three stages, accept when last two agree
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      hole_s1 <= '0;
      hole_s2 <= '0;
      hole_s3 <= '0;
      hole    <= '0;
    end else if (i_ce) begin
      hole_s1 <= i_hole;
      hole_s2 <= hole_s1;
      hole_s3 <= hole_s2;
      hole    <= (hole_s2 & ~(hole_s2 ^ hole_s3)) | (hole & (hole_s2 ^ hole_s3));
    end
  end

  // Carries ripple through positions standing at nine
  always_comb begin
    carry_in[0] = i_end_around && carry[N-1];
    for (int i = 1; i < N; i++) begin
      carry_in[i] = carry[i-1] || (carry_in[i-1] && (digit[i-1] == `DCST_DIGIT_NINE));
    end
  end

  always_comb begin
    for (int i = 0; i < N; i++) begin
      print_now[i] = is_total && impulse.valid && !impulse.special && nine_ten[i] && !printed[i];
      start[i] = (is_sub && (phase == `DCST_SUB_START))
              || (is_total && (phase == `DCST_TOTAL_START))
              || (is_sub && (phase == `DCST_CARRY_IMP) && carry_in[i]);
      stop[i]  = (is_sub && impulse.valid && !impulse.special && hole[i])
              || (is_sub && (phase == `DCST_ADD_CAM_IMP))
              || (is_sub && (phase == `DCST_CARRY_STOP))
              || print_now[i];
    end
  end

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_pos
      dcst_wheel u_wheel (
        .i_sys_clk     (i_sys_clk),
        .i_reset       (i_reset),
        .i_ce          (i_ce),
        .i_start       (start[g]),
        .i_stop        (stop[g]),
        .i_carry_clear (phase == `DCST_CARRY_UNLATCH),
        .o_digit       (digit[g]),
        .o_clutched    (clutched[g]),
        .o_nine_ten    (nine_ten[g]),
        .o_carry       (carry[g])
      );
      assign group[g*`DCST_DIGIT_W +: `DCST_DIGIT_W] = digit[g];
    end
  endgenerate

  // One print impulse per position per total cycle
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      printed <= '0;
    end else if (i_ce) begin
      if (phase == `DCST_TOTAL_START) begin
        printed <= '0;
      end else begin
        printed <= printed | print_now;
      end
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      o_print <= '0;
    end else if (i_ce) begin
      o_print.strobe  <= print_now;
      o_print.special <= impulse.special;
      o_print.digit   <= impulse.digit;
    end
  end

  // Registered view of the group and its sign
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      o_digits      <= '0;
      o_true_digits <= '0;
      o_complement  <= 1'b0;
      o_sign_fault  <= 1'b0;
    end else if (i_ce) begin
      o_digits     <= group;
      o_complement <= (digit[N-1] == `DCST_DIGIT_NINE);
      o_sign_fault <= (digit[N-1] != `DCST_DIGIT_NINE) && (digit[N-1] != `DCST_DIGIT_ZERO);
      for (int i = 0; i < N; i++) begin
        o_true_digits[i*`DCST_DIGIT_W +: `DCST_DIGIT_W] <=
          (digit[N-1] == `DCST_DIGIT_NINE) ? nines(digit[i]) : digit[i];
      end
    end
  end

  assign o_phase = phase;
  assign o_op    = op;

  // Checking aid: expected units result of a subtract cycle
  logic [`DCST_DIGIT_W-1:0] chk_base;
  logic [`DCST_DIGIT_W-1:0] chk_sensed;
  logic                     chk_seen;
  logic [`DCST_UNIT_W-1:0]  chk_sum;
  logic [`DCST_DIGIT_W-1:0] chk_expect;

  assign chk_sum    = `DCST_UNIT_W'(chk_base) + `DCST_UNIT_W'(nines(chk_sensed));
  assign chk_expect = (chk_sum >= `DCST_RADIX) ? `DCST_DIGIT_W'(chk_sum - `DCST_RADIX) : chk_sum[`DCST_DIGIT_W-1:0];

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      chk_base   <= `DCST_DIGIT_ZERO;
      chk_sensed <= `DCST_DIGIT_ZERO;
      chk_seen   <= 1'b0;
    end else if (i_ce) begin
      if (is_sub && (phase == `DCST_SUB_START) && !hole[0]) begin
        chk_base   <= digit[0];
        chk_sensed <= `DCST_DIGIT_ZERO;
        chk_seen   <= 1'b0;
      end else if (is_sub && (phase == `DCST_SUB_START)) begin
        chk_base   <= digit[0];
        chk_sensed <= impulse.digit;
        chk_seen   <= 1'b1;
      end else if (is_sub && stop[0] && !chk_seen && (phase < `DCST_ADD_CAM_IMP)) begin
        chk_sensed <= impulse.digit;
        chk_seen   <= 1'b1;
      end
    end
  end

  default clocking cb @(posedge i_sys_clk iff i_ce);
  endclocking
  default disable iff (i_reset);

  sequence s_total_run_four;
    ##106 !nine_ten[0] ##1 nine_ten[0] ##14 (digit[0] == `DCST_DIGIT_ZERO);
  endsequence

  sequence s_group_zero;
    ##193 (group == '0);
  endsequence

  AST_PHASE_STEP: assert property (phase != `DCST_PHASE_LAST |=> phase == $past(phase) + `DCST_PHASE_ONE)
    else $error("degree counter did not advance by one");
  AST_IMPULSE_MAP: assert property ((phase == 9'h063) |-> impulse.valid && impulse.digit == 4'h4)
    else $error("digit four impulse not at its cycle point");
  AST_SUB_START_ALL: assert property (is_sub && phase == `DCST_SUB_START |-> &start)
    else $error("subtract did not start every position");
  AST_TOTAL_START_ALL: assert property (is_total && phase == `DCST_TOTAL_START |-> &start ##13 &clutched)
    else $error("total did not start and engage every position");
  AST_END_AROUND: assert property (is_sub && phase == `DCST_CARRY_IMP && i_end_around && carry[N-1] |-> start[0])
    else $error("end-around carry not fed into units");
  AST_SUB_COMPLEMENT: assert property (is_sub && phase == `DCST_SUB_CHECK && !carry_in[0] |-> digit[0] == chk_expect)
    else $error("units did not advance by nines complement");
  AST_SIGN_TRUE: assert property (o_complement |-> o_true_digits[3:0] == `DCST_DIGIT_NINE - o_digits[3:0])
    else $error("true magnitude not nines complement of stored value");
  AST_TOTAL_ZERO: assert property (is_total && phase == `DCST_TOTAL_START |-> s_group_zero)
    else $error("total cycle did not return group to zero");
  AST_PRINT_DIGIT: assert property (print_now[0] |=> o_print.strobe[0] && o_print.digit == $past(impulse.digit))
    else $error("print impulse missing or wrong digit");
  AST_FOUR_STORED: assert property (is_total && phase == `DCST_TOTAL_START && digit[0] == 4'h4 |-> s_total_run_four)
    else $error("four stored did not detect at 98 and stop at zero");

  // Carry entry, hole-nine, first step and seven-stored timing
  sequence s_carry_step;
    ##13 clutched[0] ##17 clutched[0] ##1 !clutched[0];
  endsequence

  sequence s_pos1_idle;
    ##13 !clutched[1] ##18 !clutched[1];
  endsequence

  sequence s_first_step;
    ##30 $stable(digit[0]) ##1 $changed(digit[0]);
  endsequence

  sequence s_seven_detect;
    ##52 !nine_ten[4] ##1 nine_ten[4] ##1 print_now[4];
  endsequence

  sequence s_seven_stop;
    clutched[4] ##1 (!clutched[4] && (digit[4] == `DCST_DIGIT_ZERO));
  endsequence

  sequence s_seven_total;
    s_seven_detect ##12 s_seven_stop;
  endsequence

  AST_CARRY_ONE_STEP: assert property (is_sub && phase == `DCST_CARRY_IMP && carry_in[0] |-> s_carry_step)
    else $error("end-around carry did not turn units one step");
  AST_END_AROUND_OFF: assert property (is_sub && phase == `DCST_CARRY_IMP && !i_end_around |-> !start[0])
    else $error("units started by carry with end-around off");
  AST_CARRY_CLEARED: assert property (phase == `DCST_CARRY_UNLATCH |=> carry == '0)
    else $error("carry latches not cleared after carry time");
  AST_HOLE_NINE_IDLE: assert property (is_sub && phase == `DCST_SUB_START && hole[1] |-> s_pos1_idle)
    else $error("position sensing nine engaged its clutch");
  AST_FIRST_STEP: assert property (is_sub && phase == `DCST_SUB_START && !hole[0] |-> s_first_step)
    else $error("units first step not eighteen points after turning began");
  AST_SEVEN_STORED: assert property (is_total && phase == `DCST_TOTAL_START && digit[4] == 4'h7 |-> s_seven_total)
    else $error("seven stored did not detect at 44 and stop at zero at 57");
  AST_DIGITS_MIRROR: assert property (1'b1 |=> o_digits == $past(group))
    else $error("digit output does not follow the wheels");
endmodule

// ### rtl/dcst_defs.svh
// Constants for the decimal counter group: geometry, cycle points and step timing
`ifndef DCST_DEFS_SVH
`define DCST_DEFS_SVH

`define DCST_POSITIONS       8
`define DCST_DIGIT_W         4
`define DCST_PHASE_W         9
`define DCST_UNIT_W          5
`define DCST_DLY_W           4

`define DCST_PHASE_ZERO      9'h000
`define DCST_PHASE_ONE       9'h001
`define DCST_PHASE_LAST      9'h167
`define DCST_OP_LATCH        9'h15E
`define DCST_TOTAL_START     9'h15F
`define DCST_SUB_START       9'h009
`define DCST_IMP_FIRST       9'h009
`define DCST_IMP_STEP        9'h012
`define DCST_IMP_COUNT       10
`define DCST_SPECIAL_IMP     9'h15F
`define DCST_ADD_CAM_IMP     9'h0AB
`define DCST_CARRY_IMP       9'h0E1
`define DCST_CARRY_STOP      9'h0F3
`define DCST_CARRY_UNLATCH   9'h102
`define DCST_SUB_CHECK       9'h0C8

`define DCST_CLUTCH_DLY      4'hC
`define DCST_DLY_ONE         4'h1
`define DCST_DLY_ZERO        4'h0
`define DCST_UNIT_LAST       5'h11
`define DCST_UNIT_ZERO       5'h00
`define DCST_UNIT_ONE        5'h01
`define DCST_NINE_TEN_STEP   5'h04

`define DCST_DIGIT_ZERO      4'h0
`define DCST_DIGIT_ONE       4'h1
`define DCST_DIGIT_NINE      4'h9
`define DCST_RADIX           5'h0A

`endif

// ### rtl/dcst_pkg.sv
// Types shared by the decimal counter group and its wheel positions
package dcst_pkg;
`include "dcst_defs.svh"

  typedef enum logic [1:0] {
    DCST_OP_IDLE,
    DCST_OP_SUBTRACT,
    DCST_OP_TOTAL
  } dcst_op_type;

  typedef struct packed {
    logic subtract;
    logic total;
  } dcst_op_req_type;

  typedef struct packed {
    logic                       valid;
    logic                       special;
    logic [`DCST_DIGIT_W-1:0]   digit;
  } dcst_impulse_type;

  typedef struct packed {
    logic [`DCST_POSITIONS-1:0] strobe;
    logic                       special;
    logic [`DCST_DIGIT_W-1:0]   digit;
  } dcst_print_type;

  typedef logic [`DCST_POSITIONS*`DCST_DIGIT_W-1:0] dcst_group_type;

endpackage

// ### rtl/dcst_wheel.sv
// One counter wheel: clutch delays, unit stepping, nine-to-ten contact and carry latch
`timescale 1ns/1ps
`include "dcst_defs.svh"
module dcst_wheel (
  input  wire logic                     i_sys_clk,
  input  wire logic                     i_reset,
  input  wire logic                     i_ce,
  input  wire logic                     i_start,
  input  wire logic                     i_stop,
  input  wire logic                     i_carry_clear,
  output logic [`DCST_DIGIT_W-1:0]      o_digit,
  output logic                          o_clutched,
  output logic                          o_nine_ten,
  output logic                          o_carry
);
  import dcst_pkg::*;

  logic [`DCST_DLY_W-1:0]  eng_dly;
  logic [`DCST_DLY_W-1:0]  stop_dly;
  logic [`DCST_UNIT_W-1:0] unit;
  logic                    busy;
  logic                    stop_take;
  logic                    step;

  assign busy      = o_clutched || (eng_dly != `DCST_DLY_ZERO);
  assign stop_take = i_stop && (busy || i_start) && (stop_dly == `DCST_DLY_ZERO);
  assign step      = o_clutched && (unit == `DCST_UNIT_LAST);
  assign o_nine_ten = o_clutched && (o_digit == `DCST_DIGIT_NINE) && (unit >= `DCST_NINE_TEN_STEP);

  // Clutch engages a fixed delay after the start impulse
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      eng_dly <= `DCST_DLY_ZERO;
    end else if (i_ce) begin
      if (i_start && !busy) begin
        eng_dly <= `DCST_CLUTCH_DLY;
      end else if (eng_dly != `DCST_DLY_ZERO) begin
        eng_dly <= eng_dly - `DCST_DLY_ONE;
      end
    end
  end

  // Stop impulse declutches the same delay later
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      stop_dly <= `DCST_DLY_ZERO;
    end else if (i_ce) begin
      if (stop_take) begin
        stop_dly <= `DCST_CLUTCH_DLY;
      end else if (stop_dly != `DCST_DLY_ZERO) begin
        stop_dly <= stop_dly - `DCST_DLY_ONE;
      end
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      o_clutched <= 1'b0;
    end else if (i_ce) begin
      if (stop_dly == `DCST_DLY_ONE) begin
        o_clutched <= 1'b0;
      end else if (eng_dly == `DCST_DLY_ONE) begin
        o_clutched <= 1'b1;
      end
    end
  end

  // Forward-only stepping, one unit per eighteen cycle points
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      unit    <= `DCST_UNIT_ZERO;
      o_digit <= `DCST_DIGIT_ZERO;
    end else if (i_ce) begin
      if (eng_dly == `DCST_DLY_ONE) begin
        unit <= `DCST_UNIT_ZERO;
      end else if (step) begin
        unit    <= `DCST_UNIT_ZERO;
        o_digit <= (o_digit == `DCST_DIGIT_NINE) ? `DCST_DIGIT_ZERO : o_digit + `DCST_DIGIT_ONE;
      end else if (o_clutched) begin
        unit <= unit + `DCST_UNIT_ONE;
      end
    end
  end

  // Carry latch, set wins over clear
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      o_carry <= 1'b0;
    end else if (i_ce) begin
      if (step && (o_digit == `DCST_DIGIT_NINE)) begin
        o_carry <= 1'b1;
      end else if (i_carry_clear) begin
        o_carry <= 1'b0;
      end
    end
  end

  default clocking cb @(posedge i_sys_clk iff i_ce);
  endclocking
  default disable iff (i_reset);

  sequence s_engaged_then_dropped;
    ##12 o_clutched ##1 !o_clutched;
  endsequence

  AST_FORWARD_ONLY: assert property ($changed(o_digit) |->
    o_digit == (($past(o_digit) == `DCST_DIGIT_NINE) ? `DCST_DIGIT_ZERO : $past(o_digit) + `DCST_DIGIT_ONE))
    else $error("wheel moved other than one step forward");
  AST_ENGAGE_LAG: assert property (i_start && !busy && !i_stop |-> ##13 $rose(o_clutched))
    else $error("clutch did not engage twelve points after start");
  AST_STOP_LAG: assert property (stop_take && o_clutched |-> s_engaged_then_dropped)
    else $error("wheel did not declutch twelve points after stop");
  AST_LOCKED: assert property (!o_clutched |=> $stable(o_digit))
    else $error("declutched wheel changed value");
endmodule

// ### test/dcst_card_model.sv
// Card brush and print magnet model facing the decimal counter group
`timescale 1ns/1ps
`include "dcst_defs.svh"
module dcst_card_model (
  input  wire logic                  i_sys_clk,
  input  wire logic                  i_clear,
  input  wire logic [8:0]            i_phase,
  input  wire dcst_pkg::dcst_op_type i_op,
  input  wire dcst_pkg::dcst_group_type i_card_digits,
  input  wire logic [7:0]            i_card_punched,
  input  wire dcst_pkg::dcst_print_type i_print,
  output logic [7:0]                 o_hole,
  output dcst_pkg::dcst_group_type   o_printed,
  output logic [7:0]                 o_print_hit,
  output logic [8:0]                 o_print_phase [8]
);
  import dcst_pkg::*;
  int imp;

  // Brush closes around the row's impulse point, only while a subtract card passes
  always_comb begin
    o_hole = '0;
    imp = 0;
    for (int i = 0; i < 8; i++) begin
      imp = 9 + 18 * (9 - int'(i_card_digits[i*4 +: 4]));
      o_hole[i] = (i_op == DCST_OP_SUBTRACT) && i_card_punched[i] &&
                  (int'(i_phase) >= imp - 8) && (int'(i_phase) < imp + 8);
    end
  end

  // Type bar stops on the digit carried with the print strobe
  always_ff @(posedge i_sys_clk) begin
    for (int i = 0; i < 8; i++) begin
      if (i_clear) begin
        o_print_hit[i] <= 1'b0;
      end else if (i_print.strobe[i]) begin
        o_print_hit[i] <= 1'b1;
        o_printed[i*4 +: 4] <= i_print.digit;
        o_print_phase[i] <= i_phase;
      end
    end
  end
endmodule

// ### test/test_decimal_counter_subtract_total.sv
// Self-checking bench for the decimal counter group
`timescale 1ns/1ps
`include "dcst_defs.svh"
module test_decimal_counter_subtract_total;
  import dcst_pkg::*;
  logic            sys_clk;
  logic            reset;
  logic            ce;
  logic            clear;
  logic            end_around;
  dcst_op_req_type op_req;
  logic [7:0]      hole;
  logic [8:0]      phase;
  dcst_op_type     op;
  dcst_group_type  digits;
  dcst_group_type  true_digits;
  logic            complement;
  logic            sign_fault;
  dcst_print_type  print;
  dcst_group_type  card_digits;
  logic [7:0]      card_punched;
  dcst_group_type  printed;
  logic [7:0]      print_hit;
  logic [8:0]      print_phase [8];
  int              miscompares;
  int              samples_checked;

  dcst_top dcst_top_i (
    .i_sys_clk     (sys_clk),
    .i_reset       (reset),
    .i_ce          (ce),
    .i_op_req      (op_req),
    .i_end_around  (end_around),
    .i_hole        (hole),
    .o_phase       (phase),
    .o_op          (op),
    .o_digits      (digits),
    .o_true_digits (true_digits),
    .o_complement  (complement),
    .o_sign_fault  (sign_fault),
    .o_print       (print)
  );

  dcst_card_model dcst_card_model_i (
    .i_sys_clk      (sys_clk),
    .i_clear        (clear),
    .i_phase        (phase),
    .i_op           (op),
    .i_card_digits  (card_digits),
    .i_card_punched (card_punched),
    .i_print        (print),
    .o_hole         (hole),
    .o_printed      (printed),
    .o_print_hit    (print_hit),
    .o_print_phase  (print_phase)
  );

  initial sys_clk = 1'b0;
  always #20 sys_clk = ~sys_clk;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Steps falling edges until the phase counter shows p
  task automatic wait_phase(input int p);
    int n;
    n = 0;
    while (phase !== 9'(p) && n < 800) begin
      @(negedge sys_clk);
      n++;
    end
    if (n >= 800) check(32'h0, 32'h1, "phase never reached");
  endtask

  // Requests one operation for the coming machine cycle
  task automatic run_op(input logic sub, input logic tot);
    wait_phase(340);
    op_req.subtract = sub;
    op_req.total = tot;
    wait_phase(352);
    op_req = '0;
    check({30'h0, op}, tot ? {30'h0, DCST_OP_TOTAL} : {30'h0, DCST_OP_SUBTRACT}, "op window");
    check({31'h0, print.special}, 32'h1, "special impulse");
  endtask

  task automatic test_reset;
    check({23'h0, phase}, 32'h0, "reset phase");
    check({30'h0, op}, {30'h0, DCST_OP_IDLE}, "reset op");
    check(digits, 32'h0, "reset digits");
    check({24'h0, print.strobe}, 32'h0, "reset strobe");
  endtask

  task automatic test_phase;
    wait_phase(359);
    @(negedge sys_clk);
    check({23'h0, phase}, 32'h0, "phase wrap");
    wait_phase(100);
    ce = 1'b0;
    repeat (5) @(negedge sys_clk);
    check({23'h0, phase}, 32'd100, "phase frozen");
    ce = 1'b1;
    @(negedge sys_clk);
    check({23'h0, phase}, 32'd101, "phase resumes");
  endtask

  // Units punched 5, other columns blank, from a cleared group
  task automatic test_sub_units;
    card_punched = 8'h01;
    card_digits = 32'h00000005;
    end_around = 1'b0;
    run_op(1'b1, 1'b0);
    wait_phase(18);
    check(digits, 32'h0, "no motion before 21");
    wait_phase(45);
    check({28'h0, digits[3:0]}, 32'h1, "first unit after 21");
    wait_phase(120);
    check({28'h0, digits[3:0]}, 32'h4, "units stopped");
    wait_phase(200);
    check({28'h0, digits[3:0]}, 32'h4, "units locked");
    wait_phase(345);
    check(digits, 32'h99999994, "complement sum");
    check(true_digits, 32'h00000005, "true digits");
    check({31'h0, complement}, 32'h1, "complement flag");
    check({31'h0, sign_fault}, 32'h0, "sign fault");
  endtask

  // Several columns, hole 9 gives no motion
  task automatic test_sub_multi;
    card_punched = 8'h1F;
    card_digits = 32'h00021692;
    run_op(1'b1, 1'b0);
    wait_phase(345);
    check(digits, 32'h99978307, "multi column");
    check(true_digits, 32'h00021692, "multi true");
  endtask

  // Blank card adds all nines; carry out wraps to units only when enabled
  task automatic test_sub_blank(input logic ea, input logic [31:0] exp);
    card_punched = 8'h00;
    end_around = ea;
    run_op(1'b1, 1'b0);
    wait_phase(345);
    check(digits, exp, "blank card sum");
  endtask

  task automatic test_total(input logic [31:0] exp, input int pos, input int ph);
    clear = 1'b1;
    @(negedge sys_clk);
    clear = 1'b0;
    run_op(1'b0, 1'b1);
    wait_phase(345);
    check({24'h0, print_hit}, 32'hFF, "all printed");
    check(printed, exp, "printed digits");
    check({23'h0, print_phase[pos]}, 32'(ph), "print point");
    check(digits, 32'h0, "reset to zero");
    check(true_digits, 32'h0, "true digits after total");
    check({31'h0, complement}, 32'h0, "flag after total");
  endtask

  initial begin
    miscompares = 0;
    samples_checked = 0;
    reset = 1'b1;
    ce = 1'b1;
    clear = 1'b0;
    end_around = 1'b0;
    op_req = '0;
    card_digits = '0;
    card_punched = '0;
    repeat (6) @(negedge sys_clk);
    test_reset();
    reset = 1'b0;
    test_phase();
    test_sub_units();
    test_total(32'h99999994, 0, 100);
    test_sub_multi();
    test_sub_blank(1'b1, 32'h99978307);
    test_sub_blank(1'b0, 32'h99978306);
    test_total(32'h99978306, 1, 172);
    close_out();
  end

  initial begin
    #800000;
    miscompares++;
    close_out();
  end
endmodule
